// file: charger_ctrl_status_regs.sv
// control and status register bank of a single-cell charger
// assumes live status and charger events are synchronous to core_clk_in
// Overview of operation
// - forced input-limit detection bit self-clears when done
// - half-speed bit slows safety timer under limits
// - switch-off bit zero lets battery switch on
// - delay bit defers switch-off by ten seconds
// - reset-enable bit gates battery switch reset function
// - warm range caps charge voltage unless selected
// - tracking field picks 0/200/250/300 mV offset
// - effective input floor is max of both when tracking is enabled, input floor alone when disabled
// - input source type reports three-bit source code
// - charge phase reports two-bit charging state
// - thermal regulation bit mirrors thermal loop state
// - host timeout bit shows watchdog expiry
// - reverse supply fault shows boost blocked
// - charge fault code reports input/thermal/timer faults
// - battery overvoltage bit shows detected overvoltage
// - charge mode thermistor zone five codes
// - boost mode thermistor zone normal/cold/hot only
// - restore bit reloads defaults then self-clears
`timescale 1ns/1ps
module charger_ctrl_status_regs #(
  parameter logic [6:0] DEV_ADDR = charger_regs_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned BATSW_DELAY_CYCLES = int'(charger_regs_pkg::BATSW_DELAY_CYCLES_DEF),
  parameter int unsigned SAFETY_TICK_CYCLES = int'(charger_regs_pkg::SAFETY_TICK_CYCLES_DEF)
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire charger_regs_pkg::charger_status_s status_in,
  input wire charger_regs_pkg::fault_status_s fault_in,
  input wire logic boost_mode_in,
  input wire logic vbus_present_in,
  input wire logic detect_done_in,
  input wire logic input_limit_active_in,
  input wire logic cool_range_in,
  input wire logic warm_range_in,
  input wire logic watchdog_reset_in,
  input wire charger_regs_pkg::mv_t battery_mv_in,
  input wire charger_regs_pkg::mv_t input_voltage_floor_in,
  input wire charger_regs_pkg::mv_t charge_voltage_target_in,
  output logic input_detect_run_out,
  output logic safety_tick_out,
  output logic safety_timer_restart_out,
  output logic registers_restore_out,
  output logic battery_switch_on_out,
  output logic battery_switch_reset_enable_out,
  output charger_regs_pkg::mv_t charge_voltage_limit_out,
  output charger_regs_pkg::mv_t input_floor_limit_out
);
  import charger_regs_pkg::*;

  localparam int unsigned DLY_W = $clog2(BATSW_DELAY_CYCLES + 1);
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(BATSW_DELAY_CYCLES - 1);

  typedef struct packed {
    misc_ctrl_s ctrl;
    logic restore;
    logic timer_restart;
    logic sw_on;
    logic [DLY_W-1:0] dly;
    charger_status_s status;
    fault_status_s fault;
    mv_t charge_voltage_target_eff;
    mv_t floor_eff;
  } bank_s;

  bank_s s;
  bank_s next_s;
  logic [7:0] reg_addr;
  logic [7:0] wr_data;
  logic wr_strobe;
  logic [7:0] rd_data;
  logic slow;
  mv_t track_off;
  mv_t tracked_floor;
  fault_status_s fault_view;

  i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_bus (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .rd_data_in(rd_data),
    .reg_addr_out(reg_addr),
    .wr_data_out(wr_data),
    .wr_strobe_out(wr_strobe)
  );

  assign slow = s.ctrl.safety_timer_half_speed &
                (input_limit_active_in | cool_range_in | s.status.thermal_regulation_flag);

  safety_tick_gen #(
    .TICK_CYCLES(SAFETY_TICK_CYCLES)
  ) u_tick (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(s.timer_restart),
    .slow_in(slow),
    .tick_out(safety_tick_out)
  );

  // tracking offset and tracked floor
  always_comb begin
    unique case (s.ctrl.input_floor_battery_tracking)
      TRACK_DISABLED: track_off = TRACK_OFF_MV;
      TRACK_200: track_off = TRACK_200_MV;
      TRACK_250: track_off = TRACK_250_MV;
      default: track_off = TRACK_300_MV;
    endcase
  end
  assign tracked_floor = battery_mv_in + track_off;

  // in boost mode only normal, cold and hot are reported
  always_comb begin
    fault_view = fault_in;
    if (boost_mode_in && fault_in.thermistor_zone_code != ZONE_COLD &&
        fault_in.thermistor_zone_code != ZONE_HOT) begin
      fault_view.thermistor_zone_code = ZONE_NORMAL;
    end
  end

  always_comb begin
    next_s = s;
    next_s.timer_restart = 1'b0;
    // live status snapshot every cycle
    next_s.status = status_in;
    next_s.fault = fault_view;
    if (detect_done_in) begin
      next_s.ctrl.input_limit_detect_force = 1'b0;
    end
    if (watchdog_reset_in) begin
      next_s.ctrl = misc_ctrl_s'((s.ctrl & WDOG_KEEP_MASK) | (MISC_CTRL_RESET & ~WDOG_KEEP_MASK));
    end
    // host writes win over hardware clears; status offsets ignore writes
    if (wr_strobe) begin
      case (reg_addr)
        MISC_CTRL_OFFSET: next_s.ctrl = misc_ctrl_s'(wr_data);
        RESTORE_OFFSET: next_s.restore = wr_data[RESTORE_BIT];
        default: begin
        end
      endcase
    end
    if (s.restore) begin
      next_s.ctrl = MISC_CTRL_RESET;
      next_s.restore = 1'b0;
      next_s.timer_restart = 1'b1;
    end
    // battery switch control
    if (!s.ctrl.battery_switch_off) begin
      next_s.sw_on = 1'b1;
      next_s.dly = '0;
    end else if (!s.ctrl.battery_switch_off_delay || s.dly == DLY_LAST) begin
      next_s.sw_on = 1'b0;
    end else begin
      next_s.dly = s.dly + 1'b1;
    end
    // warm range cap
    if (warm_range_in && !s.ctrl.warm_charge_voltage_select &&
        charge_voltage_target_in > WARM_MAX_MV) begin
      next_s.charge_voltage_target_eff = WARM_MAX_MV;
    end else begin
      next_s.charge_voltage_target_eff = charge_voltage_target_in;
    end
    if (s.ctrl.input_floor_battery_tracking != TRACK_DISABLED &&
        tracked_floor > input_voltage_floor_in) begin
      next_s.floor_eff = tracked_floor;
    end else begin
      next_s.floor_eff = input_voltage_floor_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{ctrl: MISC_CTRL_RESET, sw_on: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      MISC_CTRL_OFFSET: rd_data = s.ctrl;
      CHARGER_STATUS_OFFSET: rd_data = s.status;
      FAULT_STATUS_OFFSET: rd_data = s.fault;
      RESTORE_OFFSET: rd_data = {s.restore, 7'h00};
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  assign input_detect_run_out = s.ctrl.input_limit_detect_force & vbus_present_in;
  assign safety_timer_restart_out = s.timer_restart;
  assign registers_restore_out = s.timer_restart;
  assign battery_switch_on_out = s.sw_on;
  assign battery_switch_reset_enable_out = s.ctrl.battery_switch_reset_enable;
  assign charge_voltage_limit_out = s.charge_voltage_target_eff;
  assign input_floor_limit_out = s.floor_eff;

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_detect_clear: assert property (
    (detect_done_in && !wr_strobe && !s.restore) |=> !s.ctrl.input_limit_detect_force)
    else $error("detect force bit not cleared after done");

  a_switch_allowed: assert property (
    !s.ctrl.battery_switch_off |=> battery_switch_on_out)
    else $error("battery switch not on while allowed");

  a_switch_immediate: assert property (
    (s.ctrl.battery_switch_off && !s.ctrl.battery_switch_off_delay) |=> !battery_switch_on_out)
    else $error("battery switch not off immediately");

  a_switch_deferred: assert property (
    ($rose(s.ctrl.battery_switch_off) && s.ctrl.battery_switch_off_delay && DLY_LAST != '0)
    |=> battery_switch_on_out)
    else $error("deferred switch-off happened early");

  a_reset_enable: assert property (
    $changed(s.ctrl.battery_switch_reset_enable) |-> $changed(battery_switch_reset_enable_out))
    else $error("reset enable output not following bit");

  a_warm_cap: assert property (
    (warm_range_in && !s.ctrl.warm_charge_voltage_select && !$changed(s.ctrl))
    |=> charge_voltage_limit_out <= WARM_MAX_MV)
    else $error("warm charge voltage above cap");

  a_floor_track: assert property (
    (s.ctrl.input_floor_battery_tracking != TRACK_DISABLED)
    |=> input_floor_limit_out >= $past(input_voltage_floor_in) &&
        input_floor_limit_out >= $past(tracked_floor))
    else $error("effective floor below either source");

  a_status_live: assert property (
    ##1 s.status == $past(status_in))
    else $error("status register not live");

  a_zone_boost: assert property (
    boost_mode_in |=> (s.fault.thermistor_zone_code == ZONE_NORMAL ||
                       s.fault.thermistor_zone_code == ZONE_COLD ||
                       s.fault.thermistor_zone_code == ZONE_HOT))
    else $error("illegal boost mode zone code");

  a_restore_defaults: assert property (
    (s.restore && !watchdog_reset_in) |=> !s.restore && s.ctrl == MISC_CTRL_RESET &&
                                          safety_timer_restart_out)
    else $error("restore did not reload defaults");

endmodule

// file: charger_regs_pkg.sv
// constants, field layouts and carriers for the charger register bank
// assumes one 25 MHz core clock shared by the bank and the charger logic
package charger_regs_pkg;

  // clock and derived cycle counts
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam longint unsigned NS_PER_S = 64'h0000_0000_3B9A_CA00;
  localparam longint unsigned NS_PER_MS = 64'h0000_0000_000F_4240;
  localparam longint unsigned BATSW_DELAY_S = 10;
  localparam longint unsigned BATSW_DELAY_CYCLES_DEF = BATSW_DELAY_S * NS_PER_S / CLK_PERIOD_NS;
  localparam longint unsigned SAFETY_TICK_MS = 1000;
  localparam longint unsigned SAFETY_TICK_CYCLES_DEF = SAFETY_TICK_MS * NS_PER_MS / CLK_PERIOD_NS;

  // register offsets
  localparam logic [7:0] MISC_CTRL_OFFSET = 8'h07;
  localparam logic [7:0] CHARGER_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] FAULT_STATUS_OFFSET = 8'h09;
  localparam logic [7:0] RESTORE_OFFSET = 8'h0B;
  localparam int unsigned RESTORE_BIT = 7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef logic [15:0] mv_t;

  // misc_charge_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic input_limit_detect_force;
    logic safety_timer_half_speed;
    logic battery_switch_off;
    logic warm_charge_voltage_select;
    logic battery_switch_off_delay;
    logic battery_switch_reset_enable;
    logic [1:0] input_floor_battery_tracking;
  } misc_ctrl_s;

  localparam misc_ctrl_s MISC_CTRL_RESET = '{
    input_limit_detect_force: 1'b0,
    safety_timer_half_speed: 1'b1,
    battery_switch_off: 1'b0,
    warm_charge_voltage_select: 1'b0,
    battery_switch_off_delay: 1'b1,
    battery_switch_reset_enable: 1'b1,
    input_floor_battery_tracking: 2'h0
  };
  // bits that survive a watchdog expiry
  localparam logic [7:0] WDOG_KEEP_MASK = 8'h2B;

  // charger_status layout
  typedef struct packed {
    logic [2:0] input_source_type;
    logic [1:0] charge_phase;
    logic power_good_flag;
    logic thermal_regulation_flag;
    logic sys_min_regulation;
  } charger_status_s;

  // fault_status layout
  typedef struct packed {
    logic host_timeout_fault;
    logic reverse_supply_fault;
    logic [1:0] charge_fault_code;
    logic battery_overvoltage_fault;
    logic [2:0] thermistor_zone_code;
  } fault_status_s;

  // reported codes
  localparam logic [2:0] SRC_NONE = 3'h0;
  localparam logic [2:0] SRC_USB_HOST = 3'h1;
  localparam logic [2:0] SRC_ADAPTER = 3'h3;
  localparam logic [2:0] SRC_OTG = 3'h7;
  localparam logic [1:0] PHASE_IDLE = 2'h0;
  localparam logic [1:0] PHASE_PRECHARGE = 2'h1;
  localparam logic [1:0] PHASE_FAST = 2'h2;
  localparam logic [1:0] PHASE_DONE = 2'h3;
  localparam logic [1:0] CFAULT_NONE = 2'h0;
  localparam logic [1:0] CFAULT_INPUT = 2'h1;
  localparam logic [1:0] CFAULT_THERMAL = 2'h2;
  localparam logic [1:0] CFAULT_TIMER = 2'h3;
  localparam logic [2:0] ZONE_NORMAL = 3'h0;
  localparam logic [2:0] ZONE_WARM = 3'h2;
  localparam logic [2:0] ZONE_COOL = 3'h3;
  localparam logic [2:0] ZONE_COLD = 3'h5;
  localparam logic [2:0] ZONE_HOT = 3'h6;

  // voltage figures in mV
  localparam mv_t WARM_MAX_MV = 16'h1004;
  localparam mv_t TRACK_OFF_MV = 16'h0000;
  localparam mv_t TRACK_200_MV = 16'h00C8;
  localparam mv_t TRACK_250_MV = 16'h00FA;
  localparam mv_t TRACK_300_MV = 16'h012C;
  localparam logic [1:0] TRACK_DISABLED = 2'h0;
  localparam logic [1:0] TRACK_200 = 2'h1;
  localparam logic [1:0] TRACK_250 = 2'h2;

  // serial bus
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

endpackage

// file: safety_tick_gen.sv
// safety timer time base with a half-rate mode
// assumes restart_in is a one-cycle pulse on the core clock
`timescale 1ns/1ps
module safety_tick_gen #(
  parameter int unsigned TICK_CYCLES = 25000000
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  input wire logic slow_in,
  output logic tick_out
);
  import charger_regs_pkg::*;

  localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic phase;
    logic tick;
  } tick_s;

  tick_s s;
  tick_s next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (restart_in) begin
      next_s.cnt = '0;
      next_s.phase = 1'b0;
    end else if (s.cnt == CNT_LAST) begin
      next_s.cnt = '0;
      // slow mode emits every second period
      if (slow_in) begin
        next_s.phase = ~s.phase;
        next_s.tick = s.phase;
      end else begin
        next_s.phase = 1'b0;
        next_s.tick = 1'b1;
      end
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_out = s.tick;

  a_half_tick: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    (s.cnt == CNT_LAST && slow_in && !restart_in && !s.phase) |=> !tick_out)
    else $error("tick emitted on skipped half-rate period");

endmodule

// file: i2c_target.sv
// serial bus target: byte pointer, auto increment, register strobes
// assumes scl and sda come from open-drain pins outside the clock domain
`timescale 1ns/1ps
module i2c_target #(
  parameter logic [6:0] DEV_ADDR = charger_regs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] reg_addr_out,
  output logic [7:0] wr_data_out,
  output logic wr_strobe_out
);
  import charger_regs_pkg::*;

  typedef enum {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_PTR, BUS_PTR_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } bus_state_e;

  typedef struct packed {
    bus_state_e st;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] shift;
    logic [2:0] bits;
    logic full;
    logic rw;
    logic nack;
    logic [7:0] ptr;
    logic drive;
    logic wr;
  } bus_s;

  bus_s s;
  bus_s next_s;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  assign scl = s.scl_sync[1];
  assign sda = s.sda_sync[1];
  assign rise = scl & ~s.scl_prev;
  assign fall = ~scl & s.scl_prev;
  assign start = scl & s.scl_prev & s.sda_prev & ~sda;
  assign stop = scl & s.scl_prev & ~s.sda_prev & sda;

  always_comb begin
    next_s = s;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.scl_prev = scl;
    next_s.sda_prev = sda;
    next_s.wr = 1'b0;
    if (start) begin
      next_s.st = BUS_ADDR;
      next_s.bits = '0;
      next_s.full = 1'b0;
      next_s.drive = 1'b0;
    end else if (stop) begin
      next_s.st = BUS_IDLE;
      next_s.drive = 1'b0;
    end else if (rise) begin
      unique case (s.st)
        BUS_ADDR, BUS_PTR, BUS_WDATA: begin
          next_s.shift = {s.shift[6:0], sda};
          next_s.bits = s.bits + 1'b1;
          next_s.full = (s.bits == 3'h7);
        end
        BUS_RDATA_ACK: begin
          next_s.nack = sda;
          next_s.ptr = s.ptr + 1'b1;
        end
        BUS_IDLE, BUS_ADDR_ACK, BUS_PTR_ACK, BUS_WDATA_ACK, BUS_RDATA: begin
        end
      endcase
    end else if (fall) begin
      unique case (s.st)
        BUS_ADDR: if (s.full) begin
          next_s.full = 1'b0;
          if (s.shift[7:1] == DEV_ADDR) begin
            next_s.drive = 1'b1;
            next_s.rw = s.shift[0];
            next_s.st = BUS_ADDR_ACK;
          end else begin
            next_s.st = BUS_IDLE;
          end
        end
        BUS_PTR: if (s.full) begin
          next_s.full = 1'b0;
          next_s.ptr = s.shift;
          next_s.drive = 1'b1;
          next_s.st = BUS_PTR_ACK;
        end
        BUS_WDATA: if (s.full) begin
          next_s.full = 1'b0;
          next_s.wr = 1'b1;
          next_s.drive = 1'b1;
          next_s.st = BUS_WDATA_ACK;
        end
        BUS_ADDR_ACK: begin
          next_s.bits = '0;
          if (s.rw) begin
            next_s.shift = rd_data_in;
            next_s.drive = ~rd_data_in[7];
            next_s.st = BUS_RDATA;
          end else begin
            next_s.drive = 1'b0;
            next_s.st = BUS_PTR;
          end
        end
        BUS_PTR_ACK: begin
          next_s.drive = 1'b0;
          next_s.st = BUS_WDATA;
        end
        BUS_WDATA_ACK: begin
          next_s.drive = 1'b0;
          next_s.ptr = s.ptr + 1'b1;
          next_s.st = BUS_WDATA;
        end
        BUS_RDATA: begin
          if (s.bits == 3'h7) begin
            next_s.drive = 1'b0;
            next_s.bits = '0;
            next_s.st = BUS_RDATA_ACK;
          end else begin
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.drive = ~s.shift[6];
            next_s.bits = s.bits + 1'b1;
          end
        end
        BUS_RDATA_ACK: begin
          if (s.nack) begin
            next_s.drive = 1'b0;
            next_s.st = BUS_IDLE;
          end else begin
            next_s.shift = rd_data_in;
            next_s.drive = ~rd_data_in[7];
            next_s.st = BUS_RDATA;
          end
        end
        BUS_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{st: BUS_IDLE, scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = s.drive;
  assign reg_addr_out = s.ptr;
  assign wr_data_out = s.shift;
  assign wr_strobe_out = s.wr;

endmodule

// file: i2c_host_model.sv
// serial bus host model reaching the register bank
// assumes pull-ups on both lines and a core clock at the host
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 6,
  parameter logic [6:0] ADDR = charger_regs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    rd_data_out = 8'h00;
    rd_valid_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic got);
    wt(2);
    sda_oe_out = !b;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    got = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic start();
    sda_oe_out = 1'b0;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_oe_out = 1'b1;
    wt(HALF);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    wt(2);
    sda_oe_out = 1'b1;
    wt(HALF);
    scl_out = 1'b1;
    wt(HALF);
    sda_oe_out = 1'b0;
    wt(HALF);
  endtask
  task automatic tx(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], a);
    bit_io(1'b1, a);
  endtask
  task automatic write_reg(input logic [7:0] ra, input logic [7:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(ra);
    tx(d);
    stop();
  endtask
  task automatic read_reg(input logic [7:0] ra);
    logic [7:0] d;
    logic a;
    start();
    tx({ADDR, 1'b0});
    tx(ra);
    start();
    tx({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, a);
    stop();
    rd_data_out = d;
    rd_valid_out = 1'b1;
    wt(1);
    rd_valid_out = 1'b0;
  endtask
endmodule

// file: test_charger_ctrl_status_regs.sv
// self-checking testbench of the charger register bank
// assumes the host model drives the serial pins over pull-ups
`timescale 1ns/1ps
module test_charger_ctrl_status_regs;
  import charger_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire sda;
  logic scl, h_oe, rd_valid, sda_drv, sda_oe, det_run, tick, restart, restore, sw_on, sw_rst;
  logic [7:0] rd_data;
  charger_status_s st = '0;
  fault_status_s ft = '0;
  logic boost = 1'b0, vbus = 1'b0, done = 1'b0, lim = 1'b0, warm = 1'b0, cool = 1'b0;
  mv_t bat = '0, flr = '0, tgt = '0, vlim, flim;
  logic [7:0] exp_q[$];
  int errors = 0;
  int checks_done = 0;
  int restarts = 0;
  always #20 clk = ~clk;
  assign sda = !(h_oe || (sda_oe && !sda_drv));
  i2c_host_model i_host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(h_oe),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid));
  charger_ctrl_status_regs #(.BATSW_DELAY_CYCLES(60), .SAFETY_TICK_CYCLES(8)) i_dut (
    .core_clk_in(clk), .rst_n_in(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe_out(sda_oe), .status_in(st), .fault_in(ft), .boost_mode_in(boost),
    .vbus_present_in(vbus), .detect_done_in(done), .input_limit_active_in(lim),
    .cool_range_in(cool), .warm_range_in(warm), .watchdog_reset_in(1'b0),
    .battery_mv_in(bat), .input_voltage_floor_in(flr), .charge_voltage_target_in(tgt),
    .input_detect_run_out(det_run), .safety_tick_out(tick), .safety_timer_restart_out(restart),
    .registers_restore_out(restore), .battery_switch_on_out(sw_on),
    .battery_switch_reset_enable_out(sw_rst), .charge_voltage_limit_out(vlim),
    .input_floor_limit_out(flim));
  task automatic summarize();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value register read expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_out(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.read_reg(a);
    cyc(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_reg(a, d);
  endtask
  task automatic gap(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1 && n < 100);
  endtask
  always @(posedge rd_valid) cmp_byte(exp_q.pop_front(), rd_data);
  always @(negedge clk) if (restart === 1'b1 && restore === 1'b1) restarts++;
  initial begin
    cyc(60000);
    errors++;
    summarize();
  end
  initial begin
    mv_t off[4];
    logic [2:0] src[4];
    logic [2:0] zn[5];
    logic [2:0] z;
    int n;
    off = '{TRACK_OFF_MV, TRACK_200_MV, TRACK_250_MV, TRACK_300_MV};
    src = '{SRC_NONE, SRC_USB_HOST, SRC_ADAPTER, SRC_OTG};
    zn = '{ZONE_NORMAL, ZONE_WARM, ZONE_COOL, ZONE_COLD, ZONE_HOT};
    void'($urandom(32'hE839CA98));
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    cmp_out("switch on", 16'h0001, 16'(sw_on));
    cmp_out("reset enable", 16'h0001, 16'(sw_rst));
    rd(MISC_CTRL_OFFSET, 8'h4C);
    rd(8'h0C, UNMAPPED_READ);
    for (int i = 0; i < 8; i++) begin
      st = charger_status_s'($urandom);
      st.input_source_type = src[i % 4];
      st.charge_phase = 2'(i);
      ft = fault_status_s'($urandom);
      ft.charge_fault_code = 2'(i);
      ft.thermistor_zone_code = zn[i % 5];
      boost = i[0];
      z = (boost && zn[i % 5] != ZONE_COLD && zn[i % 5] != ZONE_HOT) ? ZONE_NORMAL : zn[i % 5];
      rd(CHARGER_STATUS_OFFSET, st);
      wr(CHARGER_STATUS_OFFSET, ~st);
      rd(CHARGER_STATUS_OFFSET, st);
      wr(FAULT_STATUS_OFFSET, ~ft);
      rd(FAULT_STATUS_OFFSET, {ft[7:3], z});
    end
    st = '0;
    boost = 1'b0;
    vbus = 1'b1;
    wr(MISC_CTRL_OFFSET, 8'hCC);
    cmp_out("detect run", 16'h0001, 16'(det_run));
    vbus = 1'b0;
    cyc(1);
    cmp_out("detect run", 16'h0000, 16'(det_run));
    vbus = 1'b1;
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(2);
    cmp_out("detect run", 16'h0000, 16'(det_run));
    rd(MISC_CTRL_OFFSET, 8'h4C);
    wr(MISC_CTRL_OFFSET, 8'h64);
    cmp_out("switch on", 16'h0000, 16'(sw_on));
    wr(MISC_CTRL_OFFSET, 8'h4C);
    cmp_out("switch on", 16'h0001, 16'(sw_on));
    wr(MISC_CTRL_OFFSET, 8'h6C);
    cmp_out("switch on", 16'h0001, 16'(sw_on));
    cyc(56);
    cmp_out("switch on", 16'h0000, 16'(sw_on));
    wr(MISC_CTRL_OFFSET, 8'h48);
    cmp_out("reset enable", 16'h0000, 16'(sw_rst));
    for (int c = 0; c < 4; c++) begin
      bat = mv_t'(3000 + $urandom_range(1500));
      flr = mv_t'(3900 + $urandom_range(600));
      wr(MISC_CTRL_OFFSET, 8'h4C | 8'(c));
      cmp_out("input floor", (c != 0 && bat + off[c] > flr) ? bat + off[c] : flr, flim);
    end
    tgt = 16'h1068;
    warm = 1'b1;
    wr(MISC_CTRL_OFFSET, 8'h4C);
    cmp_out("charge limit", WARM_MAX_MV, vlim);
    wr(MISC_CTRL_OFFSET, 8'h5C);
    cmp_out("charge limit", 16'h1068, vlim);
    warm = 1'b0;
    gap(n);
    gap(n);
    cmp_out("tick gap", 16'h0008, 16'(n));
    lim = 1'b1;
    gap(n);
    gap(n);
    cmp_out("tick gap", 16'h0010, 16'(n));
    lim = 1'b0;
    cool = 1'b1;
    gap(n);
    gap(n);
    cmp_out("tick gap", 16'h0010, 16'(n));
    cool = 1'b0;
    st.thermal_regulation_flag = 1'b1;
    gap(n);
    gap(n);
    cmp_out("tick gap", 16'h0010, 16'(n));
    wr(MISC_CTRL_OFFSET, 8'h0C);
    gap(n);
    gap(n);
    cmp_out("tick gap", 16'h0008, 16'(n));
    st = '0;
    wr(MISC_CTRL_OFFSET, 8'h13);
    n = restarts;
    wr(RESTORE_OFFSET, 8'h80);
    cmp_out("restart count", 16'(n + 1), 16'(restarts));
    rd(MISC_CTRL_OFFSET, 8'h4C);
    rd(RESTORE_OFFSET, 8'h00);
    summarize();
  end
endmodule
